//--- hw/spa_pkg.sv
package spa_pkg;

    // Register offsets inside the board window.
    localparam logic [3:0] SPA_OFF_SPOLL = 4'h7;
    localparam logic [3:0] SPA_OFF_ADDR_STAT = 4'h9;

    // Bit positions of the poll byte and of the address status view.
    localparam int SPA_SB_RSV = 6;
    localparam int SPA_AS_CIC = 7;
    localparam int SPA_AS_ATN = 6;
    localparam int SPA_AS_SERIAL_POLL_MODE_FLAG = 5;
    localparam int SPA_AS_LISTENER_PRIMARY_ADDRESSED_FLAG = 4;
    localparam int SPA_AS_TALKER_PRIMARY_ADDRESSED_FLAG = 3;
    localparam int SPA_AS_LA = 2;
    localparam int SPA_AS_TA = 1;
    localparam int SPA_AS_MAJOR_MINOR_SELECT_FLAG = 0;

    // Reset values.
    localparam logic [7:0] SPA_STB_RST = 8'h00;
    localparam logic [7:0] SPA_RDATA_RST = 8'h00;

    // Bus command codes, seven bits after inverting the low-true data lines.
    localparam logic [6:0] SPA_CMD_SPE = 7'h18;
    localparam logic [6:0] SPA_CMD_SPD = 7'h19;
    localparam logic [6:0] SPA_CMD_UNL = 7'h3f;
    localparam logic [6:0] SPA_CMD_UNT = 7'h5f;
    localparam logic [1:0] SPA_GRP_LISTEN = 2'h1;
    localparam logic [1:0] SPA_GRP_TALK = 2'h2;
    localparam logic [1:0] SPA_GRP_SECOND = 2'h3;

    // Addressing modes: none, dual primary, extended single, extended dual.
    localparam logic [1:0] SPA_ADM_NONE = 2'h0;
    localparam logic [1:0] SPA_ADM_DUAL = 2'h1;
    localparam logic [1:0] SPA_ADM_EXT = 2'h2;
    localparam logic [1:0] SPA_ADM_EXT_DUAL = 2'h3;

    // Data settling time before the data valid strobe is asserted.
    localparam int SPA_CLK_NS = 100;
    localparam int SPA_T_SETTLE_NS = 2000;
    localparam int SPA_SETTLE_CYC = (SPA_T_SETTLE_NS + SPA_CLK_NS - 1) / SPA_CLK_NS;
    localparam int SPA_CNT_W = 8;

    // Input bus lines, all low-true as on the cable.
    typedef struct packed {
        logic atn_n;
        logic dav_n;
        logic nrfd_n;
        logic ndac_n;
        logic [7:0] dio_n;
    } spa_pins_t;

    localparam logic [11:0] SPA_PINS_IDLE = 12'hfff;

    // Own addressing configuration.
    typedef struct packed {
        logic [1:0] adm;
        logic [4:0] addr_major;
        logic [4:0] addr_minor;
    } spa_cfg_t;

    // Decoded meaning of one bus command byte.
    typedef struct packed {
        logic mla_maj;
        logic mla_min;
        logic mta_maj;
        logic mta_min;
        logic ota;
        logic unl;
        logic unt;
        logic spe;
        logic spd;
        logic sec;
        logic sec_match;
    } spa_cmd_t;

    // Poll response states.
    typedef enum logic [1:0] {
        PR_NPRS,
        PR_SETTLE,
        PR_HOLD,
        PR_DONE
    } spa_pr_t;

endpackage : spa_pkg

//--- hw/spa_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; an output bit changes once stages two and three agree.
module spa_sync import spa_pkg::*; #(
    parameter int W = 12,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } spa_sync_st_t;

    spa_sync_st_t st_r;
    spa_sync_st_t st_nxt;

    // Shift the stages and take a bit only where the last two stages agree.
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.q = ((st_r.s2 ~^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.q);
    end

    // State register.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q;
endmodule : spa_sync

//--- hw/spa_cmd_dec.sv
`timescale 1ns/1ps
// Classifies one received command byte against the own addresses.
module spa_cmd_dec import spa_pkg::*; (
    input wire logic [6:0] cmd,
    input wire spa_cfg_t cfg,
    output spa_cmd_t dec
);
    logic dual;
    logic is_lag;
    logic is_tag;

    // Minor addresses only exist in the dual primary modes.
    assign dual = (cfg.adm == SPA_ADM_DUAL) || (cfg.adm == SPA_ADM_EXT_DUAL);
    assign is_lag = (cmd[6:5] == SPA_GRP_LISTEN) && (cmd != SPA_CMD_UNL);
    assign is_tag = (cmd[6:5] == SPA_GRP_TALK) && (cmd != SPA_CMD_UNT);

    // Address and universal command decode.
    always_comb begin
        dec = '0;
        dec.mla_maj = is_lag && (cmd[4:0] == cfg.addr_major);
        dec.mla_min = is_lag && dual && (cmd[4:0] == cfg.addr_minor) && !dec.mla_maj;
        dec.mta_maj = is_tag && (cmd[4:0] == cfg.addr_major);
        dec.mta_min = is_tag && dual && (cmd[4:0] == cfg.addr_minor) && !dec.mta_maj;
        dec.ota = is_tag && !dec.mta_maj && !dec.mta_min;
        dec.unl = (cmd == SPA_CMD_UNL);
        dec.unt = (cmd == SPA_CMD_UNT);
        dec.spe = (cmd == SPA_CMD_SPE);
        dec.spd = (cmd == SPA_CMD_SPD);
        dec.sec = (cmd[6:5] == SPA_GRP_SECOND);
        dec.sec_match = dec.sec && (cmd[4:0] == cfg.addr_minor);
    end
endmodule : spa_cmd_dec

//--- hw/spa_poll_status.sv
`timescale 1ns/1ps
//Contract
// - Poll status and response byte share offset seven.
// - Seven user status bits cleared by resets.
// - Writing request service one sets pending.
// - Request service, not polled, asserts service request.
// - Affirmative poll response clears request service.
// - Request service cleared by resets and local reset.
// - Address status read-only at offset nine.
// - Controller flag is not idle nor addressed.
// - Controller flag gates attention drive.
// - Attention flag shows live attention line level.
// - Serial poll enable while talker sets poll mode.
// - Poll mode enables talker status byte return.
// - In the extended modes, own primary listen address sets listener primary.
// - Listener primary flag cleared by resets.
// - Talker and listener active are exclusive.
// - Minor address sets, major clears major-minor flag; in the extended modes addresses leave it unchanged.
// - In the extended modes, own primary talk address sets talker primary.
module spa_poll_status import spa_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic chip_reset_cmd,
    input wire logic local_message_reset_control,
    input wire spa_cfg_t cfg,
    input wire logic ctrl_idle,
    input wire logic ctrl_addressed,
    input wire logic ctrl_active_req,
    input wire spa_pins_t pins_in,
    output logic srq_oe,
    output logic atn_oe,
    output logic [7:0] dio_n_o,
    output logic dio_oe,
    output logic dav_oe,
    output logic sp_sent
);
    typedef struct packed {
        logic [7:0] stb;
        logic rsv;
        logic request_pending_flag;
        logic serial_poll_mode_flag;
        logic listener_primary_addressed_flag;
        logic talker_primary_addressed_flag;
        logic la;
        logic ta;
        logic major_minor_select_flag;
        logic controller_in_charge_flag;
        logic atn_oe;
        logic srq_oe;
        logic dio_oe;
        logic [7:0] dio_n;
        logic dav_oe;
        logic sent_rsv;
        logic aprs_done;
        spa_pr_t pr;
        logic [SPA_CNT_W-1:0] cnt;
        logic dav_prev;
        logic [7:0] rdata;
        logic sp_sent;
    } spa_st_t;

    spa_st_t st_r;
    spa_st_t st_nxt;
    spa_pins_t pins_s;
    spa_cmd_t dec;
    logic atn_on;
    logic cmd_take;
    logic do_reset;
    logic [7:0] bus_address_status;

    spa_sync #(
        .W(12),
        .RST_VAL(SPA_PINS_IDLE)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d(pins_in),
        .q(pins_s)
    );

    spa_cmd_dec u_dec (
        .cmd(~pins_s.dio_n[6:0]),
        .cfg(cfg),
        .dec(dec)
    );

    // A command is taken on the falling data valid edge while attention is low.
    assign atn_on = !pins_s.atn_n;
    assign cmd_take = atn_on && st_r.dav_prev && !pins_s.dav_n;
    assign do_reset = chip_reset_cmd;

    // Address status view, read only.
    always_comb begin
        bus_address_status = '0;
        bus_address_status[SPA_AS_CIC] = st_r.controller_in_charge_flag;
        bus_address_status[SPA_AS_ATN] = pins_s.atn_n;
        bus_address_status[SPA_AS_SERIAL_POLL_MODE_FLAG] = st_r.serial_poll_mode_flag;
        bus_address_status[SPA_AS_LISTENER_PRIMARY_ADDRESSED_FLAG] = st_r.listener_primary_addressed_flag;
        bus_address_status[SPA_AS_TALKER_PRIMARY_ADDRESSED_FLAG] = st_r.talker_primary_addressed_flag;
        bus_address_status[SPA_AS_LA] = st_r.la;
        bus_address_status[SPA_AS_TA] = st_r.ta;
        bus_address_status[SPA_AS_MAJOR_MINOR_SELECT_FLAG] = st_r.major_minor_select_flag;
    end

    // Next-state logic for addressing, poll byte and poll response.
    always_comb begin
        st_nxt = st_r;
        st_nxt.dav_prev = pins_s.dav_n;
        st_nxt.sp_sent = 1'b0;
        st_nxt.aprs_done = 1'b0;
        // Controller flag and attention drive follow the controller states.
        st_nxt.controller_in_charge_flag = !(ctrl_idle || ctrl_addressed);
        st_nxt.atn_oe = st_nxt.controller_in_charge_flag && ctrl_active_req;
        if (cmd_take) begin
            if (dec.mla_maj || dec.mla_min) begin
                if (cfg.adm[1]) begin
                    st_nxt.listener_primary_addressed_flag = 1'b1;
                end else begin
                    st_nxt.la = 1'b1;
                    st_nxt.ta = 1'b0;
                    st_nxt.major_minor_select_flag = dec.mla_min;
                end
            end
            if (dec.mta_maj || dec.mta_min) begin
                if (cfg.adm[1]) begin
                    st_nxt.talker_primary_addressed_flag = 1'b1;
                end else begin
                    st_nxt.ta = 1'b1;
                    st_nxt.la = 1'b0;
                    st_nxt.major_minor_select_flag = dec.mta_min;
                end
            end else if (dec.ota || dec.unt) begin
                st_nxt.ta = 1'b0;
            end
            if (dec.unl) begin
                st_nxt.la = 1'b0;
            end
            // Single extended mode addresses on a matching secondary; the dual mode leaves it to software.
            if (dec.sec_match && (cfg.adm == SPA_ADM_EXT)) begin
                if (st_r.listener_primary_addressed_flag) begin
                    st_nxt.la = 1'b1;
                    st_nxt.ta = 1'b0;
                end else if (st_r.talker_primary_addressed_flag) begin
                    st_nxt.ta = 1'b1;
                    st_nxt.la = 1'b0;
                end
            end
            if (dec.spe && st_r.ta) begin
                st_nxt.serial_poll_mode_flag = 1'b1;
            end
            if (dec.spd) begin
                st_nxt.serial_poll_mode_flag = 1'b0;
            end
        end
        // Poll response: send the byte once per controller standby period.
        case (st_r.pr)
            PR_NPRS: begin
                if (st_r.serial_poll_mode_flag && st_r.ta && !atn_on) begin
                    st_nxt.pr = PR_SETTLE;
                    st_nxt.dio_n = ~{st_r.stb[7], st_r.rsv, st_r.stb[5:0]};
                    st_nxt.dio_oe = 1'b1;
                    st_nxt.sent_rsv = st_r.rsv;
                    st_nxt.cnt = '0;
                end
            end
            PR_SETTLE: begin
                if (st_r.cnt < SPA_CNT_W'(SPA_SETTLE_CYC)) begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end else if (pins_s.nrfd_n) begin
                    st_nxt.dav_oe = 1'b1;
                    st_nxt.pr = PR_HOLD;
                end
            end
            PR_HOLD: begin
                if (pins_s.ndac_n) begin
                    st_nxt.dav_oe = 1'b0;
                    st_nxt.sp_sent = 1'b1;
                    st_nxt.pr = PR_DONE;
                    if (st_r.sent_rsv) begin
                        st_nxt.rsv = 1'b0;
                    end
                end
            end
            PR_DONE: begin
                st_nxt.dio_oe = 1'b0;
                if (atn_on) begin
                    st_nxt.pr = PR_NPRS;
                    st_nxt.aprs_done = st_r.sent_rsv;
                end
            end
            default: begin
                st_nxt.pr = PR_NPRS;
            end
        endcase
        // Attention during a transfer aborts it and frees the lines.
        if (atn_on && (st_r.pr == PR_SETTLE || st_r.pr == PR_HOLD)) begin
            st_nxt.pr = PR_NPRS;
            st_nxt.dio_oe = 1'b0;
            st_nxt.dav_oe = 1'b0;
        end
        // Pending drops back in the negative state after the affirmative response.
        if (st_r.aprs_done && st_r.pr == PR_NPRS) begin
            st_nxt.request_pending_flag = 1'b0;
        end
        // A write to the poll byte updates status and request service; set wins over the poll response clear, resets win over set.
        if (reg_wr && reg_addr == SPA_OFF_SPOLL) begin
            st_nxt.stb = reg_wdata & ~(8'h01 << SPA_SB_RSV);
            st_nxt.rsv = reg_wdata[SPA_SB_RSV];
            if (reg_wdata[SPA_SB_RSV]) begin
                st_nxt.request_pending_flag = 1'b1;
            end
        end
        if (local_message_reset_control) begin
            st_nxt.rsv = 1'b0;
        end
        if (do_reset) begin
            st_nxt.stb = SPA_STB_RST;
            st_nxt.rsv = 1'b0;
            st_nxt.request_pending_flag = 1'b0;
            st_nxt.serial_poll_mode_flag = 1'b0;
            st_nxt.listener_primary_addressed_flag = 1'b0;
            st_nxt.talker_primary_addressed_flag = 1'b0;
            st_nxt.la = 1'b0;
            st_nxt.ta = 1'b0;
            st_nxt.major_minor_select_flag = 1'b0;
        end
        // Service request while not in poll mode.
        st_nxt.srq_oe = st_nxt.rsv && !st_nxt.serial_poll_mode_flag;
        // Reads only sample; nothing else changes.
        if (reg_rd) begin
            if (reg_addr == SPA_OFF_SPOLL) begin
                st_nxt.rdata = {st_r.stb[7], st_r.request_pending_flag, st_r.stb[5:0]};
            end else if (reg_addr == SPA_OFF_ADDR_STAT) begin
                st_nxt.rdata = bus_address_status;
            end else begin
                st_nxt.rdata = SPA_RDATA_RST;
            end
        end
    end

    // State register; power-on reset clears everything except dio_n and dav_prev, which are set high.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.stb <= SPA_STB_RST;
            st_r.dio_n <= 8'hff;
            st_r.dav_prev <= 1'b1;
            st_r.pr <= PR_NPRS;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign srq_oe = st_r.srq_oe;
    assign atn_oe = st_r.atn_oe;
    assign dio_n_o = st_r.dio_n;
    assign dio_oe = st_r.dio_oe;
    assign dav_oe = st_r.dav_oe;
    assign sp_sent = st_r.sp_sent;

    property p_srq;
        @(posedge sys_clk) disable iff (rst)
        st_r.rsv && !st_r.serial_poll_mode_flag && !reg_wr && !local_message_reset_control && !do_reset && !cmd_take && st_r.pr == PR_NPRS |=> st_r.srq_oe;
    endproperty
    a_srq: assert property (p_srq) else $error("service request not asserted");

    property p_request_pending_flag;
        @(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == SPA_OFF_SPOLL && reg_wdata[SPA_SB_RSV] && !do_reset |=> st_r.request_pending_flag && st_r.rsv;
    endproperty
    a_request_pending_flag: assert property (p_request_pending_flag) else $error("pending not set by write");

    property p_serial_poll_mode_flag_set;
        @(posedge sys_clk) disable iff (rst)
        cmd_take && dec.spe && st_r.ta && !do_reset |=> st_r.serial_poll_mode_flag;
    endproperty
    a_serial_poll_mode_flag_set: assert property (p_serial_poll_mode_flag_set) else $error("poll mode not set");

    property p_serial_poll_mode_flag_clr;
        @(posedge sys_clk) disable iff (rst)
        cmd_take && dec.spd |=> !st_r.serial_poll_mode_flag;
    endproperty
    a_serial_poll_mode_flag_clr: assert property (p_serial_poll_mode_flag_clr) else $error("poll mode not cleared");

    property p_excl;
        @(posedge sys_clk) disable iff (rst)
        !(st_r.la && st_r.ta);
    endproperty
    a_excl: assert property (p_excl) else $error("talker and listener both active");

    property p_cic;
        @(posedge sys_clk) disable iff (rst)
        ##1 st_r.controller_in_charge_flag == !($past(ctrl_idle) || $past(ctrl_addressed));
    endproperty
    a_cic: assert property (p_cic) else $error("controller flag wrong");

    property p_atn;
        @(posedge sys_clk) disable iff (rst)
        st_r.atn_oe |-> st_r.controller_in_charge_flag;
    endproperty
    a_atn: assert property (p_atn) else $error("attention driven while idle");

    property p_chip_reset;
        @(posedge sys_clk) disable iff (rst)
        do_reset |=> st_r.stb == SPA_STB_RST && !st_r.rsv && !st_r.serial_poll_mode_flag && !st_r.listener_primary_addressed_flag && !st_r.srq_oe;
    endproperty
    a_chip_reset: assert property (p_chip_reset) else $error("chip reset incomplete");

    property p_aprs;
        @(posedge sys_clk) disable iff (rst)
        st_r.pr == PR_HOLD && pins_s.ndac_n && !atn_on && st_r.sent_rsv && !reg_wr |=> !st_r.rsv ##[1:300] !st_r.request_pending_flag;
    endproperty
    a_aprs: assert property (p_aprs) else $error("affirmative response did not clear");

    property p_settle;
        @(posedge sys_clk) disable iff (rst)
        $rose(st_r.dav_oe) |-> st_r.dio_oe && $past(st_r.dio_oe, 20);
    endproperty
    a_settle: assert property (p_settle) else $error("data not settled before valid");

    c_poll: cover property (@(posedge sys_clk) disable iff (rst) st_r.sp_sent && st_r.sent_rsv);
    c_srq: cover property (@(posedge sys_clk) disable iff (rst) $rose(st_r.srq_oe));
    c_serial_poll_mode_flag: cover property (@(posedge sys_clk) disable iff (rst) $rose(st_r.serial_poll_mode_flag));
endmodule : spa_poll_status

//--- bench/spa_bus_peer.sv
`timescale 1ns/1ps
// Far-side controller and listener; every bus line is open collector with a pull-up.
module spa_bus_peer import spa_pkg::*; (
    input wire logic sys_clk,
    input wire logic atn_oe,
    input wire logic dav_oe,
    input wire logic dio_oe,
    input wire logic [7:0] dio_n_o,
    output spa_pins_t pins
);
    logic ctl_atn_n = 1'b1;
    logic ctl_dav_n = 1'b1;
    logic ctl_nrfd_n = 1'b0;
    logic ctl_ndac_n = 1'b0;
    logic [7:0] ctl_dio_n = 8'hff;

    // Each line is the wired AND of all drivers, so a released line reads high.
    assign pins.atn_n = ctl_atn_n & ~atn_oe;
    assign pins.dav_n = ctl_dav_n & ~dav_oe;
    assign pins.nrfd_n = ctl_nrfd_n;
    assign pins.ndac_n = ctl_ndac_n;
    assign pins.dio_n = ctl_dio_n & (dio_oe ? dio_n_o : 8'hff);

    // Drives the attention line and lets the synchronisers settle.
    task automatic set_attention(input logic on);
        @(posedge sys_clk);
        ctl_atn_n <= ~on;
        repeat (8) @(posedge sys_clk);
    endtask : set_attention

    // Sends one command byte with attention asserted, then releases the data lines.
    task automatic send_cmd(input logic [7:0] b);
        @(posedge sys_clk);
        ctl_atn_n <= 1'b0;
        ctl_dio_n <= ~b;
        repeat (3) @(posedge sys_clk);
        ctl_dav_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        ctl_dav_n <= 1'b1;
        ctl_dio_n <= 8'hff;
        repeat (8) @(posedge sys_clk);
    endtask : send_cmd

    // Goes to standby, listens for one byte and accepts it after lag cycles.
    task automatic poll_read(input int lag, output logic [7:0] b, output logic ok);
        int n;
        ok = 1'b1;
        @(posedge sys_clk);
        ctl_atn_n <= 1'b1;
        repeat (lag) @(posedge sys_clk);
        ctl_nrfd_n <= 1'b1;
        n = 0;
        @(negedge sys_clk);
        while (pins.dav_n !== 1'b0 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        ok = (n < 200);
        b = ~pins.dio_n;
        repeat (lag) @(posedge sys_clk);
        ctl_nrfd_n <= 1'b0;
        ctl_ndac_n <= 1'b1;
        n = 0;
        @(negedge sys_clk);
        while (pins.dav_n !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        ok = ok & (n < 50);
        @(posedge sys_clk);
        ctl_ndac_n <= 1'b0;
    endtask : poll_read
endmodule : spa_bus_peer

//--- bench/serial_poll_and_address_status_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the poll response and address status block.
module serial_poll_and_address_status_tb_top import spa_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic chip_reset_cmd = 1'b0;
    logic local_message_reset_control = 1'b0;
    spa_cfg_t cfg = '{adm: SPA_ADM_DUAL, addr_major: 5'h05, addr_minor: 5'h06};
    logic ctrl_idle = 1'b1;
    logic ctrl_addressed = 1'b0;
    logic ctrl_active_req = 1'b0;
    spa_pins_t pins;
    logic srq_oe, atn_oe, dio_oe, dav_oe, sp_sent;
    logic [7:0] dio_n_o;
    int num_errors = 0;
    int checked = 0;
    int sp_count = 0;

    // Clock of 100 ns period.
    always #50 sys_clk = ~sys_clk;

    // Counts status bytes reported as accepted.
    always @(posedge sys_clk) if (sp_sent === 1'b1) sp_count <= sp_count + 1;

    spa_poll_status u_spa_poll_status (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .chip_reset_cmd(chip_reset_cmd),
        .local_message_reset_control(local_message_reset_control), .cfg(cfg), .ctrl_idle(ctrl_idle), .ctrl_addressed(ctrl_addressed),
        .ctrl_active_req(ctrl_active_req), .pins_in(pins), .srq_oe(srq_oe), .atn_oe(atn_oe),
        .dio_n_o(dio_n_o), .dio_oe(dio_oe), .dav_oe(dav_oe), .sp_sent(sp_sent));

    spa_bus_peer u_spa_bus_peer (.sys_clk(sys_clk), .atn_oe(atn_oe), .dav_oe(dav_oe), .dio_oe(dio_oe),
        .dio_n_o(dio_n_o), .pins(pins));

    // Prints the verdict and ends the run.
    task automatic give_verdict();
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bit

    // Register write: strobe for one edge.
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Register read with masked comparison; data is settled by the following negative edge.
    task automatic rd_check(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        check_byte(reg_rdata & mask, exp);
    endtask : rd_check

    // Reset values, idle attention level, unmapped offset.
    task automatic t_reset();
        rd_check(SPA_OFF_SPOLL, 8'hff, 8'h00);
        rd_check(SPA_OFF_ADDR_STAT, 8'hff, 8'h40);
        rd_check(4'h3, 8'hff, 8'h00);
        check_bit(srq_oe, 1'b0);
    endtask : t_reset

    // Request service sets pending and drives the service request; reads leave it alone.
    task automatic t_request();
        reg_write(4'h3, 8'hff);
        reg_write(SPA_OFF_SPOLL, 8'hc5);
        rd_check(SPA_OFF_SPOLL, 8'hff, 8'hc5);
        check_bit(srq_oe, 1'b1);
        rd_check(SPA_OFF_SPOLL, 8'hff, 8'hc5);
        rd_check(4'h3, 8'hff, 8'h00);
    endtask : t_request

    // Talk, listen, major and minor addressing in dual primary mode.
    task automatic t_address();
        u_spa_bus_peer.send_cmd(8'h45);
        rd_check(SPA_OFF_ADDR_STAT, 8'hff, 8'h02);
        u_spa_bus_peer.send_cmd(8'h25);
        rd_check(SPA_OFF_ADDR_STAT, 8'hff, 8'h04);
        u_spa_bus_peer.send_cmd(8'h46);
        rd_check(SPA_OFF_ADDR_STAT, 8'hff, 8'h03);
        u_spa_bus_peer.send_cmd(8'h45);
        rd_check(SPA_OFF_ADDR_STAT, 8'hff, 8'h02);
    endtask : t_address

    // Serial poll with a slow listener, then poll disable.
    task automatic t_poll();
        logic [7:0] b;
        logic ok;
        u_spa_bus_peer.send_cmd({1'b0, SPA_CMD_SPE});
        rd_check(SPA_OFF_ADDR_STAT, 8'hff, 8'h22);
        check_bit(srq_oe, 1'b0);
        u_spa_bus_peer.poll_read(30, b, ok);
        check_bit(ok, 1'b1);
        check_byte(b, 8'hc5);
        u_spa_bus_peer.set_attention(1'b1);
        check_byte(8'(sp_count), 8'h01);
        rd_check(SPA_OFF_SPOLL, 8'hff, 8'h85);
        check_bit(srq_oe, 1'b0);
        u_spa_bus_peer.send_cmd({1'b0, SPA_CMD_SPD});
        rd_check(SPA_OFF_ADDR_STAT, 8'hff, 8'h02);
    endtask : t_poll

    // Controller states drive the in-charge flag and the attention drive.
    task automatic t_control();
        @(posedge sys_clk);
        ctrl_idle <= 1'b0;
        ctrl_active_req <= 1'b1;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        check_bit(atn_oe, 1'b1);
        rd_check(SPA_OFF_ADDR_STAT, 8'hff, 8'h82);
        @(posedge sys_clk);
        ctrl_addressed <= 1'b1;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        check_bit(atn_oe, 1'b0);
        rd_check(SPA_OFF_ADDR_STAT, 8'h80, 8'h00);
        @(posedge sys_clk);
        ctrl_idle <= 1'b1;
        ctrl_addressed <= 1'b0;
        ctrl_active_req <= 1'b0;
    endtask : t_control

    // Local reset, extended primary flags, and chip reset clearing the status byte, address status and service request.
    task automatic t_resets();
        reg_write(SPA_OFF_SPOLL, 8'h40);
        repeat (2) @(posedge sys_clk);
        local_message_reset_control <= 1'b1;
        @(posedge sys_clk);
        local_message_reset_control <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check_bit(srq_oe, 1'b0);
        @(posedge sys_clk);
        cfg.adm <= SPA_ADM_EXT;
        u_spa_bus_peer.send_cmd(8'h25);
        u_spa_bus_peer.send_cmd(8'h45);
        rd_check(SPA_OFF_ADDR_STAT, 8'h18, 8'h18);
        reg_write(SPA_OFF_SPOLL, 8'hff);
        @(posedge sys_clk);
        chip_reset_cmd <= 1'b1;
        @(posedge sys_clk);
        chip_reset_cmd <= 1'b0;
        rd_check(SPA_OFF_SPOLL, 8'hbf, 8'h00);
        rd_check(SPA_OFF_ADDR_STAT, 8'hff, 8'h00);
        check_bit(srq_oe, 1'b0);
    endtask : t_resets

    // Secondary addressing in both extended modes, then a moved major address.
    task automatic t_retarget();
        @(posedge sys_clk);
        cfg.adm <= SPA_ADM_EXT;
        u_spa_bus_peer.send_cmd(8'h25);
        u_spa_bus_peer.send_cmd(8'h66);
        rd_check(SPA_OFF_ADDR_STAT, 8'h16, 8'h14);
        @(posedge sys_clk);
        chip_reset_cmd <= 1'b1;
        @(posedge sys_clk);
        chip_reset_cmd <= 1'b0;
        cfg.adm <= SPA_ADM_EXT_DUAL;
        cfg.addr_major <= 5'h0a;
        u_spa_bus_peer.send_cmd(8'h2a);
        u_spa_bus_peer.send_cmd(8'h66);
        rd_check(SPA_OFF_ADDR_STAT, 8'h16, 8'h10);
        @(posedge sys_clk);
        cfg.adm <= SPA_ADM_DUAL;
        u_spa_bus_peer.send_cmd(8'h4a);
        rd_check(SPA_OFF_ADDR_STAT, 8'h07, 8'h02);
        u_spa_bus_peer.send_cmd(8'h45);
        rd_check(SPA_OFF_ADDR_STAT, 8'h03, 8'h00);
    endtask : t_retarget

    // Cuts a hang short.
    initial begin
        repeat (40000) @(posedge sys_clk);
        num_errors++;
        $display("unexpected hang at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        give_verdict();
    end

    // Main sequence.
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_reset();
        t_request();
        t_address();
        t_poll();
        t_control();
        t_resets();
        t_retarget();
        give_verdict();
    end
endmodule : serial_poll_and_address_status_tb_top
